// ===== rtl/scm_pkg.sv
// Constants shared by the challenge MAC engine and its hash core
package scm_pkg;
	// Function command codes
	localparam logic [7:0] CMD_WRITE_CHAL = 8'h0C;
	localparam logic [7:0] CMD_MAC_ADDR = 8'h35;
	localparam logic [7:0] CMD_MAC_ONES = 8'h36;
	// Field widths and slot counts
	localparam int CMD_BITS = 8;
	localparam int CHAL_BITS = 64;
	localparam int ZERO_SLOTS = 8;
	localparam int RESULT_BITS = 160;
	localparam int ROUNDS = 80;
	// Net address layout
	localparam int ADDR_FAMILY_LSB = 0;
	localparam int ADDR_SERIAL_LSB = 8;
	localparam int ADDR_CRC_LSB = 56;
	localparam logic [7:0] CRC_POLY_REFLECTED = 8'h8C;
	// Fixed message words
	localparam logic [31:0] PAD_W6 = 32'h80000000;
	localparam logic [31:0] PAD_ZERO = 32'h00000000;
	localparam logic [31:0] PAD_W15 = 32'h00000100;
	localparam logic [63:0] ADDR_FIELD_ONES = 64'hFFFFFFFFFFFFFFFF;
	// Initial chaining values
	localparam logic [31:0] H0 = 32'h67452301;
	localparam logic [31:0] H1 = 32'hEFCDAB89;
	localparam logic [31:0] H2 = 32'h98BADCFE;
	localparam logic [31:0] H3 = 32'h10325476;
	localparam logic [31:0] H4 = 32'hC3D2E1F0;
	// Round constants
	localparam logic [31:0] K0 = 32'h5A827999;
	localparam logic [31:0] K1 = 32'h6ED9EBA1;
	localparam logic [31:0] K2 = 32'h8F1BBCDC;
	localparam logic [31:0] K3 = 32'hCA62C1D6;
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int PAUSE_US = 100;
	localparam int PAUSE_CYCLES = PAUSE_US * CLK_MHZ;

	// Address check byte, bits taken least significant first
	function automatic logic [7:0] crc8(input logic [55:0] data);
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			fb = c[0] ^ data[i];
			c = {1'b0, c[7:1]};
			if (fb) begin
				c = c ^ CRC_POLY_REFLECTED;
			end
		end
		return c;
	endfunction
endpackage

// ===== rtl/scm_sha1_core.sv
// Eighty-round hash core with rolling message window
module scm_sha1_core (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic [511:0] msg,
	input wire logic start,
	output logic done,
	// Result, A in the low word
	output logic [159:0] digest
);
	typedef enum logic [1:0] {CORE_IDLE, CORE_ROUND, CORE_FINAL} scm_core_state_t;

	scm_core_state_t state_q, state_d;
	logic [6:0] round_q, round_d;
	logic [31:0] a_q, b_q, c_q, d_q, e_q, a_d, b_d, c_d, d_d, e_d;
	logic done_q, done_d;
	logic [31:0] w_q [16];
	logic [31:0] w_d [16];
	logic [31:0] f, k, tmp, w_mix, w_new;
	logic advance;

	assign advance = (state_q == CORE_ROUND);
	assign w_mix = w_q[13] ^ w_q[8] ^ w_q[2] ^ w_q[0];
	assign w_new = {w_mix[30:0], w_mix[31]}; // see [RL12]

	// Window entry i holds W[t+i]; message words load in order
	for (genvar i = 0; i < 16; i++) begin : g_win
		if (i == 15) begin : g_top
			assign w_d[i] = load ? msg[511 - 32 * i -: 32] : (advance ? w_new : w_q[i]); // see [RL5]
		end else begin : g_low
			assign w_d[i] = load ? msg[511 - 32 * i -: 32] : (advance ? w_q[i + 1] : w_q[i]);
		end
	end

	always_comb begin
		if (round_q < 7'd20) begin
			f = (b_q & c_q) | (~b_q & d_q); // see [RL11]
			k = scm_pkg::K0;
		end else if (round_q < 7'd40) begin
			f = b_q ^ c_q ^ d_q;
			k = scm_pkg::K1;
		end else if (round_q < 7'd60) begin
			f = (b_q & c_q) | (b_q & d_q) | (c_q & d_q);
			k = scm_pkg::K2;
		end else begin
			f = b_q ^ c_q ^ d_q;
			k = scm_pkg::K3;
		end
		tmp = {a_q[26:0], a_q[31:27]} + f + w_q[0] + k + e_q; // see [RL13]
	end

	always_comb begin
		state_d = state_q;
		round_d = round_q;
		a_d = a_q;
		b_d = b_q;
		c_d = c_q;
		d_d = d_q;
		e_d = e_q;
		done_d = 1'b0;
		unique case (state_q)
			CORE_IDLE: begin
				if (load) begin
					a_d = scm_pkg::H0; // see [RL10]
					b_d = scm_pkg::H1;
					c_d = scm_pkg::H2;
					d_d = scm_pkg::H3;
					e_d = scm_pkg::H4;
				end
				if (start) begin
					state_d = CORE_ROUND;
					round_d = 7'd0;
				end
			end
			CORE_ROUND: begin
				e_d = d_q; // see [RL13]
				d_d = c_q;
				c_d = {b_q[1:0], b_q[31:2]};
				b_d = a_q;
				a_d = tmp;
				round_d = round_q + 7'd1;
				if (round_q == 7'(scm_pkg::ROUNDS - 1)) begin
					state_d = CORE_FINAL;
				end
			end
			CORE_FINAL: begin
				a_d = a_q + scm_pkg::H0; // see [RL14]
				b_d = b_q + scm_pkg::H1;
				c_d = c_q + scm_pkg::H2;
				d_d = d_q + scm_pkg::H3;
				e_d = e_q + scm_pkg::H4;
				done_d = 1'b1;
				state_d = CORE_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= CORE_IDLE;
			round_q <= 7'd0;
			a_q <= 32'h00000000;
			b_q <= 32'h00000000;
			c_q <= 32'h00000000;
			d_q <= 32'h00000000;
			e_q <= 32'h00000000;
			done_q <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				w_q[i] <= 32'h00000000;
			end
		end else begin
			state_q <= state_d;
			round_q <= round_d;
			a_q <= a_d;
			b_q <= b_d;
			c_q <= c_d;
			d_q <= d_d;
			e_q <= e_d;
			done_q <= done_d;
			for (int i = 0; i < 16; i++) begin
				w_q[i] <= w_d[i];
			end
		end
	end

	assign done = done_q;
	assign digest = {e_q, d_q, c_q, b_q, a_q};

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_init_vars: assert property (load && state_q == CORE_IDLE |=> a_q == scm_pkg::H0 && e_q == scm_pkg::H4) else $error("Variables not initialised on load"); // see [RL10]
	a_load_word: assert property (load |=> w_q[0] == $past(msg[511:480]) && w_q[15] == $past(msg[31:0])) else $error("Message words misloaded"); // see [RL5]
	a_k_phase: assert property (advance && round_q == 7'd40 |-> k == scm_pkg::K2 && f == ((b_q & c_q) | (b_q & d_q) | (c_q & d_q))) else $error("Wrong round function at 40"); // see [RL11]
	a_w_expand: assert property (advance && round_q < 7'd79 |=> w_q[15] == $past(w_new)) else $error("Schedule word wrong"); // see [RL12]
	a_round_span: assert property (state_q == CORE_IDLE && start |-> ##82 done_q) else $error("Hash did not take 80 rounds"); // see [RL13]
	a_final_add: assert property (state_q == CORE_FINAL |=> a_q == $past(a_q) + scm_pkg::H0 && e_q == $past(e_q) + scm_pkg::H4) else $error("Final add wrong"); // see [RL14]
endmodule

// ===== rtl/scm_engine.sv
// Challenge-response MAC engine behind a decoded single-wire slot layer
// Behaviour
// [RL1] Message is secret, challenge, constant padding
// [RL2] Address variant puts net address into padding
// [RL3] Command 36h hashes with ones address field
// [RL4] Command 35h hashes with net address field
// [RL5] Message is sixteen words, set at command
// [RL6] Secret reaches hash only, never the bus
// [RL7] Compute clears challenge; host rewrites it
// [RL8] Command 0Ch takes 64 bits, LSB first
// [RL9] Host writes no more than eight bytes
// [RL10] Variables start at standard chaining values
// [RL11] Round function and constant per quarter
// [RL12] Schedule words XOR taps rotated by one
// [RL13] Eighty rounds of temp word and shift
// [RL14] Add chaining values after last round
// [RL15] Result sent A first, LSB first
// [RL16] Pause at least 100us before hashing
// [RL17] Host holds strong pullup during computation
// [RL18] Host sends eight zeros, then 160 reads
// [RL19] Power-up challenge is zero unless dummy compute
// [RL20] Dummy compute may end after command byte
// [RL21] Host waits computation time before reading
// [RL22] Host checks result against own computation
// [RL23] Address is family, serial, check byte
// [RL24] Commands only after reset and selection
module scm_engine #(
	parameter int PAUSE_CYCLES = scm_pkg::PAUSE_CYCLES,
	parameter logic [7:0] FAMILY_CODE = 8'hA5 // Arbitrary value
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Link layer events
	input wire logic link_reset,
	input wire logic select_done,
	input wire logic slot_strobe,
	input wire logic slot_bit,
	// Stored identity
	input wire logic [63:0] secret_key,
	input wire logic [47:0] serial_number,
	// Response and status
	output logic resp_bit,
	output logic resp_active,
	output logic compute_busy
);
	localparam int PCW = $clog2(PAUSE_CYCLES + 1);

	if (PAUSE_CYCLES < 1) begin : g_chk
		$error("PAUSE_CYCLES must be at least one");
	end

	typedef enum logic [2:0] {
		ST_WAIT_RESET, ST_WAIT_SELECT, ST_CMD, ST_CHAL, ST_PAUSE, ST_HASH, ST_ZERO, ST_READ
	} scm_state_t;

	scm_state_t state_q, state_d;
	logic [7:0] bit_q, bit_d;
	logic [PCW-1:0] pause_q, pause_d;
	logic [7:0] cmd_q, cmd_d;
	logic [63:0] chal_q, chal_d;
	logic [159:0] resp_q, resp_d;
	logic [7:0] cmd_next;
	logic core_load, core_start, core_done;
	logic [159:0] core_digest;
	logic [63:0] net_addr, addr_field;
	logic [511:0] msg;
	logic incl_addr;

	// Net address, family code in the first byte on the bus
	assign net_addr[ADDR_HI_F:0] = FAMILY_CODE; // see [RL23]
	localparam int ADDR_HI_F = scm_pkg::ADDR_SERIAL_LSB - 1;
	assign net_addr[scm_pkg::ADDR_CRC_LSB-1:scm_pkg::ADDR_SERIAL_LSB] = serial_number;
	assign net_addr[63:scm_pkg::ADDR_CRC_LSB] = scm_pkg::crc8(net_addr[55:0]);

	// Message build
	assign cmd_next = {slot_bit, cmd_q[7:1]};
	assign incl_addr = (cmd_next == scm_pkg::CMD_MAC_ADDR);
	assign addr_field = incl_addr ? net_addr : scm_pkg::ADDR_FIELD_ONES; // see [RL2] see [RL3] see [RL4]
	assign msg = {
		secret_key[63:32], secret_key[31:0], // see [RL1] see [RL6]
		chal_q[31:0], chal_q[63:32],
		addr_field[31:0], addr_field[63:32],
		scm_pkg::PAD_W6,
		{8{scm_pkg::PAD_ZERO}},
		scm_pkg::PAD_W15
	};

	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		pause_d = pause_q;
		cmd_d = cmd_q;
		chal_d = chal_q;
		resp_d = resp_q;
		core_load = 1'b0;
		core_start = 1'b0;
		if (link_reset) begin
			state_d = ST_WAIT_SELECT; // see [RL24] see [RL20]
			bit_d = 8'd0;
		end else begin
			unique case (state_q)
				ST_WAIT_RESET: begin
				end
				ST_WAIT_SELECT: begin
					if (select_done) begin
						state_d = ST_CMD; // see [RL24]
						bit_d = 8'd0;
					end
				end
				ST_CMD: begin
					if (slot_strobe) begin
						cmd_d = cmd_next;
						bit_d = bit_q + 8'd1;
						if (bit_q == 8'(scm_pkg::CMD_BITS - 1)) begin
							bit_d = 8'd0;
							if (cmd_next == scm_pkg::CMD_WRITE_CHAL) begin
								state_d = ST_CHAL;
							end else if (cmd_next == scm_pkg::CMD_MAC_ONES || incl_addr) begin
								core_load = 1'b1; // see [RL5]
								chal_d = 64'h0000000000000000; // see [RL7]
								pause_d = '0;
								state_d = ST_PAUSE;
							end else begin
								state_d = ST_WAIT_RESET;
							end
						end
					end
				end
				ST_CHAL: begin
					if (slot_strobe) begin
						chal_d = {slot_bit, chal_q[63:1]}; // see [RL8]
						bit_d = bit_q + 8'd1;
						if (bit_q == 8'(scm_pkg::CHAL_BITS - 1)) begin
							state_d = ST_WAIT_RESET; // see [RL9]
						end
					end
				end
				ST_PAUSE: begin
					pause_d = pause_q + PCW'(1);
					if (pause_q == PCW'(PAUSE_CYCLES - 1)) begin
						core_start = 1'b1; // see [RL16]
						state_d = ST_HASH;
					end
				end
				ST_HASH: begin
					if (core_done) begin
						resp_d = core_digest; // see [RL6]
						bit_d = 8'd0;
						state_d = ST_ZERO; // see [RL21]
					end
				end
				ST_ZERO: begin
					if (slot_strobe) begin
						bit_d = bit_q + 8'd1;
						if (bit_q == 8'(scm_pkg::ZERO_SLOTS - 1)) begin
							bit_d = 8'd0;
							state_d = ST_READ; // see [RL18]
						end
					end
				end
				ST_READ: begin
					if (slot_strobe) begin
						resp_d = {1'b0, resp_q[159:1]}; // see [RL15]
						bit_d = bit_q + 8'd1;
						if (bit_q == 8'(scm_pkg::RESULT_BITS - 1)) begin
							state_d = ST_WAIT_RESET;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_WAIT_RESET;
			bit_q <= 8'h00;
			pause_q <= '0;
			cmd_q <= 8'h00;
			chal_q <= 64'h0000000000000000; // see [RL19]
			resp_q <= '0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			pause_q <= pause_d;
			cmd_q <= cmd_d;
			chal_q <= chal_d;
			resp_q <= resp_d;
		end
	end

	scm_sha1_core u_core (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.load(core_load),
		.msg(msg),
		.start(core_start),
		.done(core_done),
		.digest(core_digest)
	);

	assign resp_bit = resp_q[0];
	assign resp_active = (state_q == ST_READ);
	assign compute_busy = (state_q == ST_PAUSE) || (state_q == ST_HASH);

	// Cycles since the last compute command, for the pause check
	logic [31:0] since_load_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			since_load_q <= 32'h00000000;
		end else if (core_load) begin
			since_load_q <= 32'h00000000;
		end else if (since_load_q != 32'hFFFFFFFF) begin
			since_load_q <= since_load_q + 32'h00000001;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_cmd_byte_done;
		state_q == ST_CMD && slot_strobe && !link_reset && bit_q == 8'd7;
	endsequence
	sequence s_compute_taken;
		s_cmd_byte_done ##0 core_load;
	endsequence

	a_select_first: assert property (state_q != ST_CMD ##1 state_q == ST_CMD |-> $past(select_done)) else $error("Command phase without selection"); // see [RL24]
	a_chal_shift: assert property (state_q == ST_CHAL && slot_strobe && !link_reset |=> chal_q[63] == $past(slot_bit)) else $error("Challenge bit not shifted LSB first"); // see [RL8]
	a_chal_clear: assert property (s_compute_taken |=> chal_q == 64'h0 && state_q == ST_PAUSE) else $error("Challenge not cleared"); // see [RL7]
	a_pause_hold: assert property (core_start |-> since_load_q >= 32'(PAUSE_CYCLES - 1)) else $error("Hash started too early"); // see [RL16]
	a_ones_field: assert property (core_load && cmd_next == scm_pkg::CMD_MAC_ONES |-> msg[383:320] == scm_pkg::ADDR_FIELD_ONES) else $error("Address field not ones"); // see [RL3]
	a_addr_field: assert property (core_load && incl_addr |-> msg[383:352] == net_addr[31:0] && msg[351:320] == net_addr[63:32]) else $error("Address field wrong"); // see [RL4]
	a_addr_format: assert property (net_addr[7:0] == FAMILY_CODE && net_addr[55:8] == serial_number) else $error("Net address layout wrong"); // see [RL23]
	a_read_after_zero: assert property (state_q == ST_ZERO ##1 state_q == ST_READ |-> $past(bit_q) == 8'd7 && $past(slot_strobe)) else $error("Read phase without eight zero slots"); // see [RL18]
	a_first_bit: assert property (state_q == ST_HASH && core_done && !link_reset |=> resp_bit == $past(core_digest[0]) && resp_q[159:128] == $past(core_digest[159:128])) else $error("Result order wrong"); // see [RL15]
	a_resp_source: assert property ($changed(resp_q) |-> $past(state_q) == ST_HASH || $past(state_q) == ST_READ) else $error("Response loaded from elsewhere"); // see [RL6]
endmodule

// ===== verification/scm_host_model.sv
// Bus master model driving the decoded slot events of the engine
module scm_host_model (
	// Clock
	input wire logic sys_clk,
	// Slot events to the device
	output logic link_reset,
	output logic select_done,
	output logic slot_strobe,
	output logic slot_bit,
	// Device status
	input wire logic resp_bit,
	input wire logic resp_active,
	input wire logic compute_busy
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		link_reset = 1'b0;
		select_done = 1'b0;
		slot_strobe = 1'b0;
		slot_bit = 1'b0;
	end

	// Bus reset with presence, then selection; entered at a rising edge
	task automatic open_link();
		link_reset <= 1'b1;
		@(posedge sys_clk);
		link_reset <= 1'b0;
		select_done <= 1'b1;
		@(posedge sys_clk);
		select_done <= 1'b0;
	endtask

	// Write slots, least significant bit first; line inverted once released
	task automatic send(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			slot_bit <= v[i];
			slot_strobe <= 1'b1;
			@(posedge sys_clk);
		end
		slot_strobe <= 1'b0;
		slot_bit <= ~slot_bit;
		@(posedge sys_clk);
	endtask

	// One command byte after selection
	task automatic command(input logic [7:0] c);
		open_link();
		send({56'h0, c}, 8);
	endtask

	// Compute: sit out the busy window, eight zero slots, then 160 reads
	task automatic compute(input logic [7:0] c, output int busy_n, output logic [159:0] r,
		output logic act);
		command(c);
		busy_n = 0;
		while (compute_busy === 1'b1 && busy_n < 2000) begin
			@(posedge sys_clk);
			busy_n++;
		end
		send(64'h0, 8);
		for (int i = 0; i < 160; i++) begin
			slot_bit <= 1'b1;
			slot_strobe <= 1'b1;
			@(negedge sys_clk);
			r[i] = resp_bit;
			if (i == 0) begin
				act = resp_active;
			end
			@(posedge sys_clk);
		end
		slot_strobe <= 1'b0;
		slot_bit <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the challenge MAC engine
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PAUSE = 4;
	localparam logic [7:0] FAM = 8'h5B; // Arbitrary value
	localparam logic [63:0] KEY = 64'h0F1E2D3C4B5A6978;
	localparam logic [47:0] SER = 48'h1A2B3C4D5E6F;
	localparam logic [63:0] ONES = 64'hFFFFFFFFFFFFFFFF;
	logic sys_clk, reset_n, link_reset, select_done, slot_strobe, slot_bit;
	logic resp_bit, resp_active, compute_busy;
	logic [63:0] addr;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;

	scm_engine #(.PAUSE_CYCLES(PAUSE), .FAMILY_CODE(FAM)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .link_reset(link_reset),
		.select_done(select_done), .slot_strobe(slot_strobe), .slot_bit(slot_bit),
		.secret_key(KEY), .serial_number(SER), .resp_bit(resp_bit),
		.resp_active(resp_active), .compute_busy(compute_busy));

	scm_host_model host (
		.sys_clk(sys_clk), .link_reset(link_reset), .select_done(select_done),
		.slot_strobe(slot_strobe), .slot_bit(slot_bit), .resp_bit(resp_bit),
		.resp_active(resp_active), .compute_busy(compute_busy));

	function automatic logic [7:0] ref_crc(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = (c[0] ^ d[i]) ? ({1'b0, c[7:1]} ^ 8'h8C) : {1'b0, c[7:1]};
		end
		return c;
	endfunction

	function automatic logic [159:0] ref_mac(input logic [63:0] ch, input logic [63:0] a);
		logic [31:0] w [80];
		logic [31:0] va, vb, vc, vd, ve, f, k, t;
		w[0] = KEY[63:32];
		w[1] = KEY[31:0];
		w[2] = ch[31:0];
		w[3] = ch[63:32];
		w[4] = a[31:0];
		w[5] = a[63:32];
		w[6] = 32'h80000000;
		for (int i = 7; i < 80; i++) begin
			t = (i < 16) ? 32'h0 : w[i - 3] ^ w[i - 8] ^ w[i - 14] ^ w[i - 16];
			w[i] = (i == 15) ? 32'h00000100 : {t[30:0], t[31]};
		end
		va = scm_pkg::H0;
		vb = scm_pkg::H1;
		vc = scm_pkg::H2;
		vd = scm_pkg::H3;
		ve = scm_pkg::H4;
		for (int i = 0; i < 80; i++) begin
			f = (i < 20) ? ((vb & vc) | (~vb & vd)) : (i >= 40 && i < 60) ?
				((vb & vc) | (vb & vd) | (vc & vd)) : (vb ^ vc ^ vd);
			k = (i < 20) ? scm_pkg::K0 : (i < 40) ? scm_pkg::K1 : (i < 60) ? scm_pkg::K2 : scm_pkg::K3;
			t = {va[26:0], va[31:27]} + f + w[i] + k + ve;
			ve = vd;
			vd = vc;
			vc = {vb[1:0], vb[31:2]};
			vb = va;
			va = t;
		end
		return {ve + scm_pkg::H4, vd + scm_pkg::H3, vc + scm_pkg::H2, vb + scm_pkg::H1,
			va + scm_pkg::H0};
	endfunction

	task automatic chk_mac(input string name, input logic [159:0] exp, input logic [159:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Fresh challenge, exactly eight bytes
	task automatic write_chal(input logic [63:0] ch);
		host.command(scm_pkg::CMD_WRITE_CHAL);
		host.send(ch, 64);
	endtask

	// Runs one compute and judges result, pause length and read phase
	task automatic do_compute(input logic [7:0] c, input logic [63:0] ch, input logic [63:0] a);
		int bn;
		logic [159:0] r;
		logic act;
		host.compute(c, bn, r, act);
		chk_mac("mac", ref_mac(ch, a), r);
		chk_bit("pause", 1'b1, bn >= PAUSE + 80);
		chk_bit("read_phase", 1'b1, act);
		chk_bit("read_end", 1'b0, resp_active);
	endtask

	task automatic s_powerup();
		do_compute(scm_pkg::CMD_MAC_ONES, 64'h0, ONES);
	endtask

	task automatic s_addr();
		host.command(scm_pkg::CMD_MAC_ONES);
		write_chal(64'h8000000000000001);
		do_compute(scm_pkg::CMD_MAC_ADDR, 64'h8000000000000001, addr);
	endtask

	task automatic s_cleared();
		do_compute(scm_pkg::CMD_MAC_ADDR, 64'h0, addr);
	endtask

	task automatic s_plain();
		write_chal(64'hC3A55A3C96E1F00F);
		host.command(8'h77);
		host.send(64'h3C5AA5C3691E0FF0, 64);
		do_compute(scm_pkg::CMD_MAC_ONES, 64'hC3A55A3C96E1F00F, ONES);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		reset_n = 1'b0;
		addr = {ref_crc({SER, FAM}), SER, FAM};
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		s_powerup();
		s_addr();
		s_cleared();
		s_plain();
		give_verdict();
	end
endmodule
